// *** display_pkg.sv ***
// Shared constants and carrier types for the display driver serial port
`default_nettype none
package display_pkg;
	localparam int          WORD_BITS    = 16;
	localparam int          DIGITS       = 4;
	localparam int          SEGMENTS     = 7;
	localparam int          SYNC_WIDTH   = 3;
	localparam int          CLK_HZ       = 10_000_000;
	localparam int          SCLK_MAX_HZ  = 10_000_000;
	localparam logic [15:0] WORD_RESET   = 16'h0000;
	localparam logic [3:0]  DIGIT_OFF    = 4'hf;
	localparam logic [6:0]  SEGMENT_OFF  = 7'h00;
	localparam logic        POINT_OFF    = 1'h0;
	localparam logic        CHAIN_RESET  = 1'h0;
	localparam logic        DRIVE_ON_N   = 1'h0;
	localparam logic        SELECT_IDLE  = 1'h1;
	localparam logic        SCLK_IDLE    = 1'h0;
	localparam logic        DIN_IDLE     = 1'h0;

	typedef struct packed {
		logic sclk;
		logic sdin;
		logic latch_select;
	} link_s;

	localparam link_s LINK_IDLE = '{sclk: SCLK_IDLE, sdin: DIN_IDLE, latch_select: SELECT_IDLE};

	typedef enum logic [1:0] {
		ST_BLANK = 2'b01,
		ST_LIVE  = 2'b10
	} display_state_e;
endpackage : display_pkg
`default_nettype wire

// *** pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int                WIDTH     = 3,
	parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] stable_q
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts once stages two and three agree
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (reset) begin
				stable_q[i] <= RESET_VAL[i];
			end else if (s2_q[i] == s3_q[i]) begin
				stable_q[i] <= s3_q[i];
			end
		end
	end
endmodule : pin_sync
`default_nettype wire

// *** display_driver_serial_port.sv ***
// Serial load port and drive-line gating of the four-digit display driver
`timescale 1ns/1ps
`default_nettype none
module display_driver_serial_port #(
	parameter logic CS_VARIANT = 1'h1
) (
	input  wire logic                                 clk,
	input  wire logic                                 reset,
	input  wire logic                                 sclk,
	input  wire logic                                 sdin,
	input  wire logic                                 latch_select,
	input  wire logic [display_pkg::DIGITS-1:0]       digit_on,
	input  wire logic [display_pkg::SEGMENTS-1:0]     segment_on,
	input  wire logic                                 point_on,
	output logic                                      chain_out,
	output logic                                      chain_oe_n,
	output logic [display_pkg::WORD_BITS-1:0]         command_word,
	output logic                                      command_valid,
	output logic                                      configured,
	output logic [display_pkg::DIGITS-1:0]            digit_sink_lines,
	output logic [display_pkg::SEGMENTS-1:0]          segment_source_lines,
	output logic                                      point_source_line
);
	display_pkg::link_s                        link_in;
	display_pkg::link_s                        link_s_q;
	display_pkg::link_s                        link_prev_q;
	display_pkg::display_state_e               state_q;
	display_pkg::display_state_e               state_d;
	logic [display_pkg::WORD_BITS-1:0]         shift_q;
	logic [display_pkg::WORD_BITS-1:0]         shift_d;
	logic [display_pkg::WORD_BITS-1:0]         word_q;
	logic                                      word_valid_q;
	logic                                      out_bit_q;
	logic                                      chain_q;
	logic                                      chain_oe_n_q;
	logic [display_pkg::DIGITS-1:0]            digit_q;
	logic [display_pkg::SEGMENTS-1:0]          segment_q;
	logic                                      point_q;
	logic                                      configured_q;
	wire                                       sclk_rise;
	wire                                       sclk_fall;
	wire                                       select_rise;
	wire                                       clock_gate;
	wire                                       shift_en;
	wire                                       chain_en;
	wire                                       live;
	wire [display_pkg::DIGITS-1:0]             digit_d;
	wire [display_pkg::SEGMENTS-1:0]           segment_d;
	wire                                       point_d;

	// Sampling at 10MHz resolves slow links only; the 10MHz pin limit
	// needs a faster core clock to be met in full
	assign link_in = '{sclk: sclk, sdin: sdin, latch_select: latch_select};

	pin_sync #(
		.WIDTH     (display_pkg::SYNC_WIDTH),
		.RESET_VAL (display_pkg::LINK_IDLE)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (link_in),
		.stable_q (link_s_q)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			link_prev_q <= display_pkg::LINK_IDLE;
		end else begin
			link_prev_q <= link_s_q;
		end
	end

	assign sclk_rise   = link_s_q.sclk & ~link_prev_q.sclk;
	assign sclk_fall   = ~link_s_q.sclk & link_prev_q.sclk;
	assign select_rise = link_s_q.latch_select & ~link_prev_q.latch_select;
	// Select high masks every serial clock edge in this variant
	assign clock_gate  = ~CS_VARIANT | ~link_s_q.latch_select;
	assign shift_en    = sclk_rise & clock_gate;
	assign chain_en    = sclk_fall & clock_gate;
	assign shift_d     = {shift_q[display_pkg::WORD_BITS-2:0], link_s_q.sdin};

	// Shift register plus one extra stage for the chain delay
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_q   <= display_pkg::WORD_RESET;
			out_bit_q <= display_pkg::CHAIN_RESET;
		end else if (shift_en) begin
			shift_q   <= shift_d;
			out_bit_q <= shift_q[display_pkg::WORD_BITS-1];
		end
	end

	// Half a clock later the oldest bit reaches the pin
	always_ff @(posedge clk) begin
		if (reset) begin
			chain_q <= display_pkg::CHAIN_RESET;
		end else if (chain_en) begin
			chain_q <= out_bit_q;
		end
	end

	// Pin never released, so the enable stays asserted
	always_ff @(posedge clk) begin
		if (reset) begin
			chain_oe_n_q <= display_pkg::DRIVE_ON_N;
		end else begin
			chain_oe_n_q <= display_pkg::DRIVE_ON_N;
		end
	end

	// A cascade commits every device on one select edge
	always_ff @(posedge clk) begin
		if (reset) begin
			word_q       <= display_pkg::WORD_RESET;
			word_valid_q <= 1'h0;
		end else begin
			word_valid_q <= select_rise;
			if (select_rise) begin
				word_q <= shift_q;
			end
		end
	end

	// First commit leaves the blanked state for good
	always_comb begin
		case (state_q)
			display_pkg::ST_BLANK: state_d = select_rise ? display_pkg::ST_LIVE : display_pkg::ST_BLANK;
			display_pkg::ST_LIVE:  state_d = display_pkg::ST_LIVE;
			default:               state_d = display_pkg::ST_BLANK;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= display_pkg::ST_BLANK;
		end else begin
			state_q <= state_d;
		end
	end

	assign live = (state_q == display_pkg::ST_LIVE);

	// Own flop so the status pin is not a decode of the state bits
	always_ff @(posedge clk) begin
		if (reset) begin
			configured_q <= 1'h0;
		end else begin
			configured_q <= (state_d == display_pkg::ST_LIVE);
		end
	end

	// Digits sink current; off lines sit at supply
	assign digit_d   = live ? ~digit_on : display_pkg::DIGIT_OFF;
	// Segments source current; off lines sit at ground
	assign segment_d = live ? segment_on : display_pkg::SEGMENT_OFF;
	assign point_d   = live ? point_on : display_pkg::POINT_OFF;

	always_ff @(posedge clk) begin
		if (reset) begin
			digit_q   <= display_pkg::DIGIT_OFF;
			segment_q <= display_pkg::SEGMENT_OFF;
			point_q   <= display_pkg::POINT_OFF;
		end else begin
			digit_q   <= digit_d;
			segment_q <= segment_d;
			point_q   <= point_d;
		end
	end

	assign chain_out            = chain_q;
	assign chain_oe_n           = chain_oe_n_q;
	assign command_word         = word_q;
	assign command_valid        = word_valid_q;
	assign configured           = configured_q;
	assign digit_sink_lines     = digit_q;
	assign segment_source_lines = segment_q;
	assign point_source_line    = point_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_select_high;
		CS_VARIANT && link_s_q.latch_select;
	endsequence

	sequence s_shift_edge;
		shift_en;
	endsequence

	sequence s_fall_edge;
		chain_en;
	endsequence

	shift_in_a: assert property (s_shift_edge |=> shift_q == {$past(shift_q[display_pkg::WORD_BITS-2:0]),
		$past(link_s_q.sdin)})
		else $error("shift register did not take the sampled bit");

	word_commit_a: assert property (select_rise |=> (word_q == $past(shift_q)) && word_valid_q)
		else $error("select edge did not commit the shift register");

	select_hold_a: assert property (s_select_high ##1 s_select_high |-> $stable(shift_q))
		else $error("shift register moved while select was high");

	select_ignore_a: assert property ((s_select_high and sclk_fall) |=> $stable(chain_q))
		else $error("chain output moved on a masked clock edge");

	// Fall four cycles after the rise: the shortest level the link may hold
	chain_delay_a: assert property (s_shift_edge ##4 s_fall_edge |=>
		chain_q == $past(shift_q[display_pkg::WORD_BITS-1], 5))
		else $error("chain output is not the bit from sixteen clocks back");

	chain_fall_a: assert property (!chain_en |=> $stable(chain_q))
		else $error("chain output changed away from a falling edge");

	chain_drive_a: assert property (chain_oe_n_q == display_pkg::DRIVE_ON_N)
		else $error("chain output released");

	digit_off_a: assert property (live && !digit_on[0] |=> digit_q[0])
		else $error("switched-off digit line not high");

	segment_off_a: assert property (live && !segment_on[0] && !point_on |=> !segment_q[0] && !point_q)
		else $error("switched-off segment line not low");

	blank_hold_a: assert property (!live ##1 !live |-> digit_q == display_pkg::DIGIT_OFF &&
		segment_q == display_pkg::SEGMENT_OFF && !point_q)
		else $error("display lit before configuration");
endmodule : display_driver_serial_port
`default_nettype wire

// *** serial_master_model.sv ***
// Serial bus master model that loads the display driver port
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
	input  wire logic               clk,
	output var  display_pkg::link_s link
);
	initial link = display_pkg::LINK_IDLE;

	// Four core cycles a half period give an 800 ns serial clock
	task automatic half();
		repeat (4) @(posedge clk);
		#1;
	endtask : half

	// Data changes with the fall, well clear of the sampling rise; clock left high
	task automatic bit_out(input logic b);
		link.sclk = 1'h0;
		link.sdin = b;
		half();
		link.sclk = 1'h1;
		half();
	endtask : bit_out

	// Select only moves while the serial clock is low
	task automatic open_frame();
		link.sclk = 1'h0;
		half();
		link.latch_select = 1'h0;
		half();
	endtask : open_frame

	// One commit closes the whole chain; released data line flips so no stale level is trusted
	task automatic close_frame();
		link.sclk = 1'h0;
		half();
		link.latch_select = 1'h1;
		link.sdin = ~link.sdin;
	endtask : close_frame
endmodule : serial_master_model
`default_nettype wire

// *** display_driver_serial_port_tb.sv ***
// Self-checking bench for the display driver serial port
`timescale 1ns/1ps
`default_nettype none
module display_driver_serial_port_tb;
	logic               clk        = 1'h0;
	logic               reset      = 1'h1;
	logic [3:0]         digit_on   = 4'h0;
	logic [6:0]         segment_on = 7'h00;
	logic               point_on   = 1'h0;
	display_pkg::link_s link;
	logic               chain_out, chain_oe_n, command_valid, configured, point_source_line;
	logic [15:0]        command_word;
	logic [3:0]         digit_sink_lines;
	logic [6:0]         segment_source_lines;
	logic               plain_chain_out, plain_valid;
	logic [15:0]        plain_word;
	int                 miscompares = 0;
	int                 checks_done = 0;
	int                 cycles      = 0;
	logic [31:0]        stream      = 32'ha5c3_3c96;

	always #50 clk = ~clk;

	serial_master_model master (.clk(clk), .link(link));

	display_driver_serial_port uut (
		.clk(clk), .reset(reset), .sclk(link.sclk), .sdin(link.sdin), .latch_select(link.latch_select),
		.digit_on(digit_on), .segment_on(segment_on), .point_on(point_on), .chain_out(chain_out),
		.chain_oe_n(chain_oe_n), .command_word(command_word), .command_valid(command_valid),
		.configured(configured), .digit_sink_lines(digit_sink_lines),
		.segment_source_lines(segment_source_lines), .point_source_line(point_source_line)
	);

	// Plain load variant on the same link: clocks count whatever select does
	display_driver_serial_port #(.CS_VARIANT(1'h0)) uut_plain (
		.clk(clk), .reset(reset), .sclk(link.sclk), .sdin(link.sdin), .latch_select(link.latch_select),
		.digit_on(digit_on), .segment_on(segment_on), .point_on(point_on), .chain_out(plain_chain_out),
		.chain_oe_n(), .command_word(plain_word), .command_valid(plain_valid),
		.configured(), .digit_sink_lines(), .segment_source_lines(), .point_source_line()
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic give_verdict();
		if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// Bounded wait: the commit pulse lasts a single cycle
	task automatic wait_commit();
		int n;
		n = 0;
		while (command_valid !== 1'h1 && n < 20) begin
			settle(1);
			n++;
		end
		check(command_valid, 1'h1);
		check(plain_valid, 1'h1);
	endtask : wait_commit

	// Requests for light before any commit must leave everything dark
	task automatic test_blank();
		digit_on   = 4'hf;
		segment_on = 7'h7f;
		point_on   = 1'h1;
		settle(4);
		check(digit_sink_lines, display_pkg::DIGIT_OFF);
		check(segment_source_lines, display_pkg::SEGMENT_OFF);
		check(point_source_line, display_pkg::POINT_OFF);
		check(configured, 1'h0);
		check(chain_oe_n, display_pkg::DRIVE_ON_N);
	endtask : test_blank

	// 32 bits in one frame: chain lags 16.5 clocks, word is the last 16
	task automatic test_cascade();
		master.open_frame();
		for (int j = 0; j < 32; j++) begin
			master.bit_out(stream[31-j]);
			if (j >= 17) check(chain_out, stream[48-j]);
			check(chain_oe_n, display_pkg::DRIVE_ON_N);
		end
		master.close_frame();
		wait_commit();
		check(command_word, stream[15:0]);
		check(configured, 1'h1);
		check(chain_out, stream[16]);
		check(plain_word, stream[15:0]);
		check(plain_chain_out, stream[16]);
	endtask : test_cascade

	task automatic test_display();
		digit_on   = 4'ha;
		segment_on = 7'h55;
		point_on   = 1'h1;
		settle(3);
		check(digit_sink_lines, 4'h5);
		check(segment_source_lines, 7'h55);
		check(point_source_line, 1'h1);
		digit_on   = 4'h0;
		segment_on = 7'h00;
		point_on   = 1'h0;
		settle(3);
		check(digit_sink_lines, 4'hf);
		check(segment_source_lines, 7'h00);
		check(point_source_line, 1'h0);
	endtask : test_display

	// Clocking while deselected must neither shift nor move the chain
	task automatic test_deselected();
		logic [15:0] flipped;
		for (int i = 0; i < 16; i++) begin
			master.bit_out(~stream[i]);
			flipped[15-i] = ~stream[i];
		end
		master.open_frame();
		master.close_frame();
		wait_commit();
		check(command_word, stream[15:0]);
		check(chain_out, stream[16]);
		check(plain_word, flipped);
		check(plain_chain_out, stream[0]);
	endtask : test_deselected

	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		settle(10);
		reset = 1'h0;
		test_blank();
		test_cascade();
		test_display();
		test_deselected();
		give_verdict();
	end
endmodule : display_driver_serial_port_tb
`default_nettype wire
